// ==== verilog/cic_top.sv ====
// Purpose: Carrier interval counter with alternating reloads
// Assumes: Register port is on core_clk; pending_clear and timer_clk_sel from same-clock logic
// Notes:   Outputs all come from flip-flops
`timescale 1ns/100ps
`default_nettype none
`include "cic_defs.svh"

module cic_top (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       pending_clear,
	input  wire logic [1:0] timer_clk_sel,
	output logic            carrier_out,
	output logic            timer_clk_src,
	output logic            interval_pending,
	output logic            carrier_interrupt_line,
	output logic      [7:0] irq_vector
);
	import cic_pkg::*;

	// Does the phase that just ended raise the interrupt
	function automatic logic irq_fires(input logic [1:0] sel, input logic ended_high);
		unique case (sel)
			`CIC_IRQ_AT_LOW:  irq_fires = !ended_high;
			`CIC_IRQ_AT_HIGH: irq_fires = ended_high;
			`CIC_IRQ_AT_BOTH: irq_fires = 1'b1;
			default:          irq_fires = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [7:0]  carrier_control;
	logic [7:0]  high_phase_reload;
	logic [7:0]  low_phase_reload;
	logic [7:0]  next_carrier_control;
	logic [7:0]  next_high_phase_reload;
	logic [7:0]  next_low_phase_reload;
	logic [7:0]  next_reg_rdata;
	logic        ctrl_wr;
	logic        start;

	cic_state_t  state;
	cic_state_t  next_state;
	logic [7:0]  cnt;
	logic [7:0]  next_cnt;
	logic        use_high;
	logic        next_use_high;
	logic        next_carrier_out;
	logic        next_pending;
	logic        borrow;
	logic        oneshot_done;
	logic        tick;

	cic_prescaler u_prescaler (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_sel  (carrier_control[`CIC_BIT_CLK_HI:`CIC_BIT_CLK_LO]),
		.tick     (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Register file
	assign ctrl_wr = reg_wr && (reg_addr == `CIC_ADDR_CONTROL);
	assign start   = ctrl_wr && reg_wdata[`CIC_BIT_RUN] && !carrier_control[`CIC_BIT_RUN];

	always_comb begin
		next_carrier_control   = carrier_control;
		next_high_phase_reload = high_phase_reload;
		next_low_phase_reload  = low_phase_reload;
		// Self-stop after one shot; a software write in the same cycle wins
		if (oneshot_done) begin
			next_carrier_control[`CIC_BIT_RUN] = 1'b0;
		end
		if (ctrl_wr) begin
			next_carrier_control = reg_wdata;
		end
		if (reg_wr && reg_addr == `CIC_ADDR_HIGH) begin
			next_high_phase_reload = reg_wdata;
		end
		if (reg_wr && reg_addr == `CIC_ADDR_LOW) begin
			next_low_phase_reload = reg_wdata;
		end
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			unique case (reg_addr)
				`CIC_ADDR_CONTROL: next_reg_rdata = carrier_control;
				`CIC_ADDR_HIGH:    next_reg_rdata = high_phase_reload;
				`CIC_ADDR_LOW:     next_reg_rdata = low_phase_reload;
				default:           next_reg_rdata = `CIC_ZERO8;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			carrier_control   <= `CIC_CONTROL_RESET;
			high_phase_reload <= `CIC_RELOAD_RESET;
			low_phase_reload  <= `CIC_RELOAD_RESET;
			reg_rdata         <= `CIC_ZERO8;
		end else begin
			carrier_control   <= next_carrier_control;
			high_phase_reload <= next_high_phase_reload;
			low_phase_reload  <= next_low_phase_reload;
			reg_rdata         <= next_reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter: a load tick, value decrements, then a borrow tick gives value+2
	assign borrow       = (state == CIC_ST_COUNT) && tick && (cnt == `CIC_ZERO8);
	assign oneshot_done = borrow && use_high && !carrier_control[`CIC_BIT_REPEAT];

	always_comb begin
		next_state       = state;
		next_cnt         = cnt;
		next_use_high    = use_high;
		next_carrier_out = carrier_out;
		unique case (state)
			CIC_ST_IDLE: begin
				next_state = CIC_ST_IDLE;
			end
			CIC_ST_LOAD: begin
				if (tick) begin
					next_cnt   = use_high ? high_phase_reload : low_phase_reload;
					next_state = CIC_ST_COUNT;
				end
			end
			CIC_ST_COUNT: begin
				if (borrow) begin
					next_carrier_out = !carrier_out;
					next_use_high    = !use_high;
					next_state       = oneshot_done ? CIC_ST_IDLE : CIC_ST_LOAD;
				end else if (tick) begin
					next_cnt = cnt - 8'h01;
				end
			end
		endcase
		if (ctrl_wr && !reg_wdata[`CIC_BIT_RUN]) begin
			next_state = CIC_ST_IDLE;
		end
		// Level bit only steers the flip-flop while stopped, at start or in the write that stops it
		if (ctrl_wr && (!carrier_control[`CIC_BIT_RUN] || !reg_wdata[`CIC_BIT_RUN])) begin
			next_carrier_out = reg_wdata[`CIC_BIT_LEVEL];
		end
		if (start) begin
			next_state    = CIC_ST_LOAD;
			next_use_high = 1'b0;
		end
	end

	// Set wins over clear
	always_comb begin
		next_pending = interval_pending;
		if (pending_clear) begin
			next_pending = 1'b0;
		end
		if (borrow && irq_fires(carrier_control[`CIC_BIT_IRQ_HI:`CIC_BIT_IRQ_LO], use_high)) begin
			next_pending = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state                  <= CIC_ST_IDLE;
			cnt                    <= `CIC_ZERO8;
			use_high               <= 1'b0;
			carrier_out            <= 1'b0;
			interval_pending       <= 1'b0;
			carrier_interrupt_line <= 1'b0;
			timer_clk_src          <= 1'b0;
			irq_vector             <= `CIC_ZERO8;
		end else begin
			state                  <= next_state;
			cnt                    <= next_cnt;
			use_high               <= next_use_high;
			carrier_out            <= next_carrier_out;
			interval_pending       <= next_pending;
			carrier_interrupt_line <= interval_pending && carrier_control[`CIC_BIT_IRQ_EN];
			timer_clk_src          <= (timer_clk_sel == `CIC_TIMER_SEL_EXT) && carrier_out;
			irq_vector             <= `CIC_IRQ_VECTOR;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	start_load_a: assert property (@(posedge core_clk) disable iff (rst)
		start |=> (state == CIC_ST_LOAD) && !use_high)
		else $error("start did not load the low reload value");

	load_value_a: assert property (@(posedge core_clk) disable iff (rst)
		(state == CIC_ST_LOAD && tick && !ctrl_wr) |=>
		(cnt == ($past(use_high) ? $past(high_phase_reload) : $past(low_phase_reload))))
		else $error("counter not loaded from the reload register");

	borrow_alt_a: assert property (@(posedge core_clk) disable iff (rst)
		(borrow && !ctrl_wr) |=> (carrier_out != $past(carrier_out)) && (use_high != $past(use_high)))
		else $error("borrow did not toggle output and alternate reload");

	div2_tick_a: assert property (@(posedge core_clk) disable iff (rst)
		(carrier_control[`CIC_BIT_CLK_HI:`CIC_BIT_CLK_LO] == `CIC_CLK_DIV2 && tick && !ctrl_wr) |=> !tick)
		else $error("divide by two ticked twice in a row");

	irq_invalid_a: assert property (@(posedge core_clk) disable iff (rst)
		(carrier_control[`CIC_BIT_IRQ_HI:`CIC_BIT_IRQ_LO] == 2'h3 && !interval_pending) |=> !interval_pending)
		else $error("invalid interrupt time setting raised pending");

	irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		carrier_interrupt_line == ($past(interval_pending) && $past(carrier_control[`CIC_BIT_IRQ_EN])))
		else $error("interrupt line does not follow pending and enable");

	halt_idle_a: assert property (@(posedge core_clk) disable iff (rst)
		!carrier_control[`CIC_BIT_RUN] |-> (state == CIC_ST_IDLE))
		else $error("counter runs while halted");

	level_set_a: assert property (@(posedge core_clk) disable iff (rst)
		(ctrl_wr && !carrier_control[`CIC_BIT_RUN]) |=> (carrier_out == $past(reg_wdata[`CIC_BIT_LEVEL])))
		else $error("level bit did not set the toggle flip-flop");

	oneshot_stop_a: assert property (@(posedge core_clk) disable iff (rst)
		(oneshot_done && !ctrl_wr) |=> (state == CIC_ST_IDLE) && !carrier_control[`CIC_BIT_RUN])
		else $error("one-shot did not stop after the high phase");

	pending_set_a: assert property (@(posedge core_clk) disable iff (rst)
		(borrow && irq_fires(carrier_control[`CIC_BIT_IRQ_HI:`CIC_BIT_IRQ_LO], use_high)) |=>
		interval_pending ##1 carrier_interrupt_line == carrier_control[`CIC_BIT_IRQ_EN] || $past(ctrl_wr))
		else $error("selected interval end did not set pending");

	timer_src_a: assert property (@(posedge core_clk) disable iff (rst)
		(timer_clk_sel != `CIC_TIMER_SEL_EXT) |=> !timer_clk_src)
		else $error("timer clock source driven while not selected");
endmodule
`default_nettype wire

// ==== verilog/cic_defs.svh ====
// Purpose: Constants for the carrier interval counter
// Assumes: Registers are reached by 8-bit register address
// Notes:   Holds definitions only
//
// Summary of operation
// - The counter is an 8-bit down counter that reloads itself from one of two reload registers on each borrow.
// - The block works as an interval timer whose request goes out on interrupt line 2 with vector ech.
// - The output toggle flip-flop is offered as a clock source to the 16-bit timer.
// - Starting the counter loads the low reload value first.
// - Each borrow loads the other reload value, alternating high and low until one-shot mode stops after the high phase.
// - Control bits 7:6 pick the count clock as the oscillator clock divided by 1, 2, 4 or 8.
// - Control bits 5:4 fire the interrupt after the low phase, the high phase, or both, and 11 fires nothing.
// - Control bit 3 lets the interrupt request out when 1 and holds it back when 0.
// - Control bit 2 runs the counter when 1 and halts it when 0.
// - Control bit 1 picks one-shot (0) or repeating (1) operation.
// - Control bit 0 sets the toggle flip-flop low (0) or high (1).
// - Each output phase lasts its reload value plus 2 count-clock periods, roles swapped when bit 0 is 1.
// - The 16-bit timer takes the toggle flip-flop as its clock when its clock select holds 11.
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

`define CIC_ADDR_CONTROL   8'hf3
`define CIC_ADDR_HIGH      8'hf4
`define CIC_ADDR_LOW       8'hf5
`define CIC_CONTROL_RESET  8'h00
`define CIC_RELOAD_RESET   8'h00

`define CIC_BIT_CLK_HI     7
`define CIC_BIT_CLK_LO     6
`define CIC_BIT_IRQ_HI     5
`define CIC_BIT_IRQ_LO     4
`define CIC_BIT_IRQ_EN     3
`define CIC_BIT_RUN        2
`define CIC_BIT_REPEAT     1
`define CIC_BIT_LEVEL      0

`define CIC_IRQ_AT_LOW     2'h0
`define CIC_IRQ_AT_HIGH    2'h1
`define CIC_IRQ_AT_BOTH    2'h2

`define CIC_CLK_DIV1       2'h0
`define CIC_CLK_DIV2       2'h1
`define CIC_CLK_DIV4       2'h2
`define CIC_CLK_DIV8       2'h3

`define CIC_TIMER_SEL_EXT  2'h3
`define CIC_IRQ_VECTOR     8'hec
`define CIC_ZERO8          8'h00

`endif

// ==== verilog/cic_pkg.sv ====
// Purpose: Types for the carrier interval counter
// Assumes: Nothing beyond the constants header
// Notes:   One-hot state codes
package cic_pkg;
	typedef enum logic [2:0] {
		CIC_ST_IDLE  = 3'h1,
		CIC_ST_LOAD  = 3'h2,
		CIC_ST_COUNT = 3'h4
	} cic_state_t;
endpackage

// ==== verilog/cic_prescaler.sv ====
// Purpose: Count-clock enable from the oscillator clock
// Assumes: core_clk is the oscillator clock
// Notes:   Free running, so a new divider takes effect within 8 cycles
`timescale 1ns/100ps
`default_nettype none
`include "cic_defs.svh"

module cic_prescaler (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [1:0] clk_sel,
	output logic            tick
);
	logic [2:0] div;
	logic [2:0] next_div;

	always_comb begin
		next_div = div + 3'h1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div <= 3'h0;
		end else begin
			div <= next_div;
		end
	end

	// Tick once every 1, 2, 4 or 8 cycles
	always_comb begin
		unique case (clk_sel)
			`CIC_CLK_DIV1: tick = 1'b1;
			`CIC_CLK_DIV2: tick = div[0];
			`CIC_CLK_DIV4: tick = &div[1:0];
			`CIC_CLK_DIV8: tick = &div;
		endcase
	end
endmodule
`default_nettype wire

// ==== tb/cic_timer_model.sv ====
// Purpose: 16-bit timer model clocked by the carrier flip-flop
// Assumes: Same clock domain as the counter
// Notes:   Count clears while another clock source is selected
`timescale 1ns/100ps
`default_nettype none
module cic_timer_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [1:0]  timer_clk_sel,
	input  wire logic        timer_clk_src,
	output logic      [15:0] count
);
	logic prev;
	always_ff @(posedge core_clk) begin
		prev <= timer_clk_src;
		if (rst || timer_clk_sel != 2'h3)
			count <= 16'h0000;
		else if (timer_clk_src && !prev)
			count <= count + 16'h0001;
	end
endmodule
`default_nettype wire

// ==== tb/cic_top_tb.sv ====
// Purpose: Self-checking bench for the carrier interval counter
// Assumes: Reload values kept small so runs stay short
// Notes:   Phase lengths are counted in core_clk edges between toggles
`timescale 1ns/100ps
`default_nettype none
module cic_top_tb;
	logic        core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, pending_clear = 1'h0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, irq_vector, lo, hi, ctl;
	logic [1:0]  timer_clk_sel = 2'h0;
	logic        carrier_out, timer_clk_src, interval_pending, carrier_interrupt_line;
	logic        prev_co = 1'h0, rd_seen = 1'h0;
	logic [15:0] tcount;
	logic [15:0] q_rd[$], q_len[$];
	int          n_errors = 0, comparisons = 0, cyc = 0;
	always #12.5 core_clk = ~core_clk;
	cic_top i_cic_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pending_clear(pending_clear),
		.timer_clk_sel(timer_clk_sel), .carrier_out(carrier_out), .timer_clk_src(timer_clk_src),
		.interval_pending(interval_pending), .carrier_interrupt_line(carrier_interrupt_line),
		.irq_vector(irq_vector));
	cic_timer_model i_cic_timer_model (.core_clk(core_clk), .rst(rst), .timer_clk_sel(timer_clk_sel),
		.timer_clk_src(timer_clk_src), .count(tcount));
	////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk);
		reg_rd = 1'h1;
		reg_addr = a;
		q_rd.push_back({8'h00, e});
		@(negedge core_clk);
		reg_rd = 1'h0;
	endtask
	// Prescaler phase is free running, so the first phase is not timed
	task automatic run(input logic [7:0] c, input int n);
		logic v;
		lo = 8'h01 + 8'($urandom % 15);
		hi = 8'h01 + 8'($urandom % 15);
		wr(8'hf5, lo);
		wr(8'hf4, hi);
		wr(8'hf3, c & 8'hfb);
		wr(8'hf3, c);
		v = carrier_out;
		for (int i = 0; carrier_out === v; i++) begin
			if (i > 4000) begin
				n_errors++;
				tally_and_finish();
			end
			@(negedge core_clk);
		end
		// Let the monitor take the untimed toggle before any length is queued
		@(negedge core_clk);
		for (int i = 0; i < n; i++)
			q_len.push_back(16'((int'(i % 2 == 0 ? hi : lo) + 2) << c[7:6]));
		for (int i = 0; q_len.size() > 0; i++) begin
			if (i > 3000) begin
				n_errors++;
				tally_and_finish();
			end
			@(negedge core_clk);
		end
	endtask
	////////////////////////////////
	always @(posedge core_clk) begin
		cyc++;
		if (rd_seen)
			check({8'h00, reg_rdata}, q_rd.pop_front());
		rd_seen = reg_rd;
		if (carrier_out !== prev_co) begin
			if (q_len.size() > 0)
				check(16'(cyc), q_len.pop_front());
			cyc = 0;
			prev_co = carrier_out;
		end
	end
	////////////////////////////////
	initial begin
		void'($urandom(32939));
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'h0;
		rd(8'hf3, 8'h00);
		rd(8'hf4, 8'h00);
		rd(8'hf5, 8'h00);
		rd(8'hf6, 8'h00);
		check({8'h00, irq_vector}, 16'h00ec);
		// Repeat mode, every divider, invalid interrupt time
		for (int s = 0; s < 4; s++) begin
			timer_clk_sel = 2'h0;
			@(negedge core_clk);
			timer_clk_sel = 2'h3;
			run({s[1:0], 6'h3e}, 3);
			// Stop at once, a short low phase would add a timer edge
			wr(8'hf3, 8'h00);
			rd(8'hf5, lo);
			check(tcount, 16'h0002);
			check({15'h0, interval_pending}, 16'h0000);
			repeat (2) @(negedge core_clk);
			check({15'h0, carrier_out}, 16'h0000);
		end
		wr(8'hf3, 8'h01);
		timer_clk_sel = 2'h0;
		repeat (20) @(negedge core_clk);
		check({14'h0, carrier_out, timer_clk_src}, 16'h0002);
		// One-shot through every interrupt time code
		for (int k = 0; k < 4; k++) begin
			ctl = {2'h0, k[1:0], k[0], 1'h1, 1'h0, 1'($urandom)};
			run(ctl, 1);
			repeat (4) @(negedge core_clk);
			check({15'h0, carrier_out}, {15'h0, ctl[0]});
			rd(8'hf3, ctl & 8'hfb);
			check({14'h0, interval_pending, carrier_interrupt_line}, {14'h0, k != 3, k == 1});
			@(negedge core_clk);
			pending_clear = 1'h1;
			@(negedge core_clk);
			pending_clear = 1'h0;
			repeat (2) @(negedge core_clk);
			check({14'h0, interval_pending, carrier_interrupt_line}, 16'h0000);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
